// ---- rtl/sensor_seq_pkg.sv ----
// constants and state codes for the sensor power-up sequencer
package sensor_seq_pkg;

  // clock and documented times, each in its own unit
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_SUPPLY_GAP_US = 100;
  localparam int unsigned T_XTAL_SETTLE_MS = 30;
  localparam int unsigned T_RESET_HOLD_MS = 1;
  localparam int unsigned T_PLL_LOCK_MS = 1;
  localparam int unsigned INIT_EXTCLKS = 150000;

  // least times rounded up to whole cycles
  localparam int unsigned SUPPLY_GAP_CYC =
    (T_SUPPLY_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned XTAL_SETTLE_CYC =
    (T_XTAL_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_HOLD_CYC =
    (T_RESET_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PLL_LOCK_CYC =
    (T_PLL_LOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // wait timer width
  localparam int TIMER_W = 32;

  // supply enable bit positions, in power-up order
  localparam int SUP_PLL = 0;
  localparam int SUP_ANA = 1;
  localparam int SUP_IO = 2;
  localparam int SUP_CORE = 3;
  localparam int SUP_TX = 4;
  localparam int SUP_N = 5;

  // sensor control register write that starts streaming
  localparam logic [15:0] SENSOR_CTRL_ADDR = 16'h301A;
  localparam int STREAM_BIT = 2;
  localparam logic [15:0] STREAM_ON_DATA = 16'h0004;

  // sequencer states, one-hot
  typedef enum logic [12:0] {
    ST_OFF  = 13'h0001,
    ST_PLL  = 13'h0002,
    ST_ANA  = 13'h0004,
    ST_IO   = 13'h0008,
    ST_CORE = 13'h0010,
    ST_TX   = 13'h0020,
    ST_XTAL = 13'h0040,
    ST_RSTH = 13'h0080,
    ST_INIT = 13'h0100,
    ST_CFG  = 13'h0200,
    ST_LOCK = 13'h0400,
    ST_STRM = 13'h0800,
    ST_RUN  = 13'h1000
  } seq_state_e;

endpackage

// ---- rtl/timer_if.sv ----
// wait timer link between the sequencer and its timer
`timescale 1ns/10ps
`default_nettype none
interface timer_if;
  import sensor_seq_pkg::*;
  logic start; // load the count
  logic [TIMER_W-1:0] load; // count to load
  logic step; // one count down
  logic done; // count reached zero
  modport ctrl (output start, output load, output step, input done);
  modport tmr (input start, input load, input step, output done);
endinterface
`default_nettype wire

// ---- rtl/seq_timer.sv ----
// loadable down counter that times each sequencer wait
`timescale 1ns/10ps
`default_nettype none
module seq_timer
  import sensor_seq_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic arst_n, // asynchronous reset, active low
  timer_if.tmr tif // timer control
);

  typedef struct packed {
    logic armed;
    logic [TIMER_W-1:0] count;
  } tmr_s;

  tmr_s cur;
  tmr_s next_tmr;

  // load on start, else count down on each step until zero
  always_comb begin
    next_tmr = cur;
    if (tif.start) begin
      next_tmr.armed = 1'b1;
      next_tmr.count = tif.load;
    end else if (cur.armed && tif.step && cur.count != '0) begin
      next_tmr.count = cur.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_tmr;
    end
  end

  // done stands until the next load
  assign tif.done = cur.armed && (cur.count == '0);

endmodule
`default_nettype wire

// ---- rtl/sensor_power_up_sequencer.sv ----
// host-side power-up and start-up sequencer for an image sensor
//
// Behaviour
// - the PLL supply is on no later than any other supply.
// - the analog and pixel supplies go on together 100 us after PLL.
// - the I/O supply goes on 100 us after the analog supplies.
// - the core supply goes on 100 us after the I/O supply.
// - the serial transmitter supply goes on last, 100 us after core.
// - the input clock is enabled after supplies are good, then 30 ms.
// - sensor reset stays asserted at least 1 ms after supplies settle.
// - after reset release, wait 150000 input clocks before access.
// - after configuration, wait at least 1 ms for PLL lock.
// - streaming starts by writing 1 to bit 2 of the control register.
`timescale 1ns/10ps
`default_nettype none
module sensor_power_up_sequencer
  import sensor_seq_pkg::*;
#(
  parameter int unsigned GAP_CYC = SUPPLY_GAP_CYC,
  parameter int unsigned XTAL_CYC = XTAL_SETTLE_CYC,
  parameter int unsigned RST_CYC = RESET_HOLD_CYC,
  parameter int unsigned LOCK_CYC = PLL_LOCK_CYC,
  parameter int unsigned INIT_CLKS = INIT_EXTCLKS
) (
  input wire logic clock, // 100 MHz system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic start, // begin power-up, taken in the off state
  input wire logic abort, // drop everything back to off
  input wire logic supply_good, // board says all rails stable (pin)
  input wire logic external_input_clock, // sensor input clock (pin)
  input wire logic cfg_done, // pulse: sensor configuration written
  input wire logic wr_ack, // pulse: register write accepted
  output logic pll_supply_en, // PLL rail enable
  output logic analog_supply_en, // analog rail enable
  output logic pixel_array_supply_en, // pixel rail enable
  output logic io_supply_en, // I/O rail enable
  output logic core_supply_en, // core rail enable
  output logic serial_tx_supply_en, // serial transmitter rail enable
  output logic external_input_clock_en, // clock source enable
  output logic sensor_reset_n, // sensor hard reset, active low
  output logic cfg_req, // level: write sensor configuration now
  output logic wr_req, // level: register write request
  output logic [15:0] wr_addr, // register write address
  output logic [15:0] wr_data, // register write data
  output logic busy, // sequence in progress
  output logic streaming // sensor told to stream
);

  typedef struct packed {
    seq_state_e state;
    logic [SUP_N-1:0] supply;
    logic clk_en;
    logic rst_rel;
    logic wr_req;
    logic [2:0] clk_sync;
    logic [1:0] good_sync;
  } seq_s;

  seq_s cur;
  seq_s next_seq;
  logic tmr_start;
  logic [TIMER_W-1:0] tmr_load;
  logic clk_rise;
  logic rails_ok;

  timer_if tif ();

  seq_timer u_timer (
    .clock (clock),
    .arst_n (arst_n),
    .tif (tif)
  );

  // synchronised pin views; first stages feed only the second
  assign clk_rise = cur.clk_sync[1] & ~cur.clk_sync[2];
  assign rails_ok = cur.good_sync[1];

  // timer hookup; input clock edges pace the initialisation wait
  assign tif.start = tmr_start;
  assign tif.load = tmr_load;
  assign tif.step = (cur.state == ST_INIT) ? clk_rise : 1'b1;

  // sequence steps
  always_comb begin
    next_seq = cur;
    next_seq.clk_sync = {cur.clk_sync[1:0], external_input_clock};
    next_seq.good_sync = {cur.good_sync[0], supply_good};
    tmr_start = 1'b0;
    tmr_load = '0;
    unique case (cur.state)
      ST_OFF: begin
        if (start) begin
          next_seq.state = ST_PLL;
          next_seq.supply[SUP_PLL] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(GAP_CYC - 1);
        end
      end
      ST_PLL: begin
        if (tif.done) begin
          next_seq.state = ST_ANA;
          next_seq.supply[SUP_ANA] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(GAP_CYC - 1);
        end
      end
      ST_ANA: begin
        if (tif.done) begin
          next_seq.state = ST_IO;
          next_seq.supply[SUP_IO] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(GAP_CYC - 1);
        end
      end
      ST_IO: begin
        if (tif.done) begin
          next_seq.state = ST_CORE;
          next_seq.supply[SUP_CORE] = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(GAP_CYC - 1);
        end
      end
      ST_CORE: begin
        if (tif.done) begin
          next_seq.state = ST_TX;
          next_seq.supply[SUP_TX] = 1'b1;
        end
      end
      ST_TX: begin
        if (rails_ok) begin
          next_seq.state = ST_XTAL;
          next_seq.clk_en = 1'b1;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(XTAL_CYC - 1);
        end
      end
      ST_XTAL: begin
        if (tif.done) begin
          next_seq.state = ST_RSTH;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(RST_CYC - 1);
        end
      end
      ST_RSTH: begin
        if (tif.done) begin
          next_seq.state = ST_INIT;
          next_seq.rst_rel = 1'b1;
          tmr_start = 1'b1;
          // one extra count covers an input clock edge that was still in
          // the synchroniser when the sensor reset was released
          tmr_load = TIMER_W'(INIT_CLKS + 1);
        end
      end
      ST_INIT: begin
        if (tif.done) begin
          next_seq.state = ST_CFG;
        end
      end
      ST_CFG: begin
        if (cfg_done) begin
          next_seq.state = ST_LOCK;
          tmr_start = 1'b1;
          tmr_load = TIMER_W'(LOCK_CYC - 1);
        end
      end
      ST_LOCK: begin
        if (tif.done) begin
          next_seq.state = ST_STRM;
          next_seq.wr_req = 1'b1;
        end
      end
      ST_STRM: begin
        if (wr_ack) begin
          next_seq.state = ST_RUN;
          next_seq.wr_req = 1'b0;
        end
      end
      ST_RUN: begin
        next_seq.state = ST_RUN;
      end
      default: begin
        next_seq.state = ST_OFF;
        next_seq.supply = '0;
        next_seq.clk_en = 1'b0;
        next_seq.rst_rel = 1'b0;
        next_seq.wr_req = 1'b0;
      end
    endcase
    // abort wins everywhere and leaves all rails off
    if (abort) begin
      next_seq.state = ST_OFF;
      next_seq.supply = '0;
      next_seq.clk_en = 1'b0;
      next_seq.rst_rel = 1'b0;
      next_seq.wr_req = 1'b0;
      tmr_start = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{state: ST_OFF, default: '0};
    end else begin
      cur <= next_seq;
    end
  end

  // outputs; the analog and pixel rails share one enable
  assign pll_supply_en = cur.supply[SUP_PLL];
  assign analog_supply_en = cur.supply[SUP_ANA];
  assign pixel_array_supply_en = cur.supply[SUP_ANA];
  assign io_supply_en = cur.supply[SUP_IO];
  assign core_supply_en = cur.supply[SUP_CORE];
  assign serial_tx_supply_en = cur.supply[SUP_TX];
  assign external_input_clock_en = cur.clk_en;
  assign sensor_reset_n = cur.rst_rel;
  assign cfg_req = (cur.state == ST_CFG);
  assign wr_req = cur.wr_req;
  assign wr_addr = SENSOR_CTRL_ADDR;
  assign wr_data = STREAM_ON_DATA;
  assign busy = (cur.state != ST_OFF) && (cur.state != ST_RUN);
  assign streaming = (cur.state == ST_RUN);

  // checking helpers: cycles since a rail rose, since clock enable,
  // in the current state, and input clock edges during init that were
  // sampled after reset release (first two init cycles hold stale samples)
  logic [SUP_N-1:0] prev_supply;
  logic [31:0] gap_cnt;
  logic [31:0] hold_cnt;
  logic [31:0] dwell_cnt;
  logic [31:0] edge_cnt;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_supply <= '0;
      gap_cnt <= '0;
      hold_cnt <= '0;
      dwell_cnt <= '0;
      edge_cnt <= '0;
    end else begin
      prev_supply <= cur.supply;
      gap_cnt <= (|(cur.supply & ~prev_supply)) ? 32'h1 : gap_cnt + 32'h1;
      hold_cnt <= cur.clk_en ? hold_cnt + 32'h1 : 32'h0;
      dwell_cnt <= (next_seq.state != cur.state) ? 32'h0 : dwell_cnt + 32'h1;
      edge_cnt <= (cur.state != ST_INIT) ? 32'h0 :
                  edge_cnt + {31'h0, clk_rise && (dwell_cnt > 32'h1)};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence abort_seen;
    abort;
  endsequence
  sequence write_pending;
    cur.wr_req && !wr_ack;
  endsequence

  pll_first_a: assert property (
    (|cur.supply[SUP_N-1:1]) |-> cur.supply[SUP_PLL])
    else $error("rail on before PLL rail");
  ana_gap_a: assert property (
    $rose(cur.supply[SUP_ANA]) |-> gap_cnt == GAP_CYC && pll_supply_en)
    else $error("analog rail spacing wrong");
  io_gap_a: assert property (
    $rose(cur.supply[SUP_IO]) |-> gap_cnt == GAP_CYC && analog_supply_en)
    else $error("io rail spacing wrong");
  core_gap_a: assert property (
    $rose(cur.supply[SUP_CORE]) |-> gap_cnt == GAP_CYC && io_supply_en)
    else $error("core rail spacing wrong");
  tx_gap_a: assert property (
    $rose(cur.supply[SUP_TX]) |-> gap_cnt == GAP_CYC && core_supply_en)
    else $error("tx rail spacing wrong");
  clk_after_rails_a: assert property (
    $rose(cur.clk_en) |-> (&cur.supply) && $past(rails_ok))
    else $error("input clock enabled before rails good");
  reset_hold_a: assert property (
    $rose(cur.rst_rel) |-> hold_cnt == XTAL_CYC + RST_CYC)
    else $error("reset released at wrong time");
  init_wait_a: assert property (
    (cur.state == ST_INIT && next_seq.state == ST_CFG)
      |-> edge_cnt >= INIT_CLKS)
    else $error("sensor accessed before init clocks");
  lock_wait_a: assert property (
    (cur.state == ST_LOCK && next_seq.state == ST_STRM)
      |-> dwell_cnt == LOCK_CYC - 1)
    else $error("stream start before PLL lock wait");
  stream_write_a: assert property (
    write_pending and !abort |=> cur.wr_req && wr_addr == SENSOR_CTRL_ADDR
      && wr_data[STREAM_BIT])
    else $error("stream write dropped or wrong");
  abort_off_a: assert property (
    abort_seen |=> cur.supply == '0 && !cur.clk_en && !cur.rst_rel
      && cur.state == ST_OFF)
    else $error("abort did not return to off");

endmodule
`default_nettype wire

// ---- dv/sensor_model.sv ----
// behavioural sensor and board model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module sensor_model
  import sensor_seq_pkg::*;
#(
  parameter int unsigned INIT_CLKS = 5
) (
  input wire logic clock, // system clock
  input wire logic [4:0] rails, // rail enables, pll in bit 0
  input wire logic clock_en, // input clock source enable
  input wire logic sensor_reset_n, // sensor reset, active low
  input wire logic cfg_req, // configuration request
  input wire logic wr_req, // register write request
  input wire logic [15:0] wr_addr, // write address
  input wire logic [15:0] wr_data, // write data
  input wire logic [3:0] ack_delay, // cycles before write ack
  output logic supply_good, // rails stable
  output logic external_input_clock, // sensor input clock
  output logic cfg_done, // configuration written
  output logic wr_ack, // write accepted
  output logic stream_on, // sensor producing frames
  output logic fault, // sticky access or order fault
  output wire logic [11:0] pix_data // parallel pixel pins
);
  int unsigned edges = 0;
  int unsigned good_cnt = 0;
  int unsigned wait_cnt = 0;
  initial begin
    {supply_good, cfg_done, wr_ack, stream_on, fault} = 5'h00;
    external_input_clock = 1'b0;
  end
  // input clock runs only while its source is enabled, low otherwise;
  // it toggles off the system clock's rising edge to avoid a sampling race
  always begin
    #20;
    external_input_clock = clock_en ? ~external_input_clock : 1'b0;
  end
  // start-up counted in input clocks after reset release
  always @(posedge external_input_clock or negedge sensor_reset_n) begin
    if (!sensor_reset_n) edges <= 0;
    else if (edges < INIT_CLKS) edges <= edges + 1;
  end
  // pixel pins float while reset is held
  assign pix_data = sensor_reset_n ? {12{stream_on}} : 12'hZZZ;
  // board rails, host handshakes and the control register
  always @(posedge clock) begin
    good_cnt <= rails[4] ? good_cnt + 1 : 0;
    supply_good <= rails[4] && good_cnt >= 2;
    cfg_done <= cfg_req && !cfg_done;
    wait_cnt <= (wr_req && !wr_ack) ? wait_cnt + 1 : 0;
    wr_ack <= wr_req && !wr_ack && wait_cnt == ack_delay;
    if (|rails[4:1] && !rails[0]) fault <= 1'b1;
    if ((cfg_req || wr_req) && edges < INIT_CLKS) fault <= 1'b1;
    if (wr_ack && wr_addr !== SENSOR_CTRL_ADDR) fault <= 1'b1;
    if (!sensor_reset_n) stream_on <= 1'b0;
    else if (wr_ack) stream_on <= wr_data[STREAM_BIT];
  end
endmodule
`default_nettype wire

// ---- dv/sensor_power_up_sequencer_tb_top.sv ----
// self-checking bench for the sensor power-up sequencer
`timescale 1ns/10ps
`default_nettype none
module sensor_power_up_sequencer_tb_top;
  import sensor_seq_pkg::*;
  localparam int unsigned G = 8;
  localparam int unsigned X = 20;
  localparam int unsigned R = 10;
  localparam int unsigned L = 10;
  localparam int unsigned N = 5;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic abort = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic supply_good, external_input_clock, cfg_done, wr_ack;
  logic stream_on, fault;
  logic pll_supply_en, analog_supply_en, pixel_array_supply_en;
  logic io_supply_en, core_supply_en, serial_tx_supply_en;
  logic external_input_clock_en, sensor_reset_n, cfg_req, wr_req;
  logic busy, streaming;
  logic [15:0] wr_addr, wr_data;
  wire logic [11:0] pix_data;
  wire logic [4:0] rails = {serial_tx_supply_en, core_supply_en,
    io_supply_en, analog_supply_en, pll_supply_en};
  wire logic [7:0] now = {wr_req, sensor_reset_n, external_input_clock_en,
    rails};
  logic [7:0] prev = 8'h00;
  logic [31:0] cyc = 32'h0;
  logic [31:0] t_cd = 32'h0;
  logic [31:0] t [8];
  int failures = 0;
  int comparisons = 0;

  always #5 clock = ~clock;

  sensor_power_up_sequencer #(.GAP_CYC(G), .XTAL_CYC(X), .RST_CYC(R),
    .LOCK_CYC(L), .INIT_CLKS(N)) dut (
    .clock(clock), .arst_n(arst_n), .start(start), .abort(abort),
    .supply_good(supply_good),
    .external_input_clock(external_input_clock), .cfg_done(cfg_done),
    .wr_ack(wr_ack), .pll_supply_en(pll_supply_en),
    .analog_supply_en(analog_supply_en),
    .pixel_array_supply_en(pixel_array_supply_en),
    .io_supply_en(io_supply_en), .core_supply_en(core_supply_en),
    .serial_tx_supply_en(serial_tx_supply_en),
    .external_input_clock_en(external_input_clock_en),
    .sensor_reset_n(sensor_reset_n), .cfg_req(cfg_req), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy),
    .streaming(streaming));

  sensor_model #(.INIT_CLKS(N)) partner (
    .clock(clock), .rails(rails), .clock_en(external_input_clock_en),
    .sensor_reset_n(sensor_reset_n), .cfg_req(cfg_req), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .ack_delay(ack_delay),
    .supply_good(supply_good),
    .external_input_clock(external_input_clock), .cfg_done(cfg_done),
    .wr_ack(wr_ack), .stream_on(stream_on), .fault(fault),
    .pix_data(pix_data));

  // rise time of each rail, clock enable, reset release and write request
  always @(posedge clock) begin
    cyc <= cyc + 1;
    prev <= now;
    for (int i = 0; i < 8; i++) if (now[i] && !prev[i]) t[i] <= cyc;
    if (cfg_done) t_cd <= cyc;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // every output of the sequencer except wr_addr and wr_data is off, pixel pins float
  task automatic check_off();
    cmp({20'h0, rails, pixel_array_supply_en, external_input_clock_en,
      sensor_reset_n, cfg_req, wr_req, busy, streaming}, 32'h0);
    cmp({20'h0, pix_data}, {20'h0, 12'hZZZ});
  endtask

  // abort pulse, outputs off one cycle later and stay off
  task automatic drop();
    abort = 1'b1;
    @(negedge clock);
    abort = 1'b0;
    start = 1'b0;
    check_off();
    repeat (3) @(negedge clock);
    check_off();
  endtask

  // whole power-up with start held high throughout, write ack delay set by dly
  task automatic run_seq(input logic [3:0] dly);
    ack_delay = dly;
    start = 1'b1;
    for (int i = 0; i < 3000 && streaming !== 1'b1; i++) @(negedge clock);
    start = 1'b0;
    cmp(t[1] - t[0], G);
    cmp(t[2] - t[1], G);
    cmp(t[3] - t[2], G);
    cmp(t[4] - t[3], G);
    cmp(t[5] > t[4], 1);
    cmp(t[6] - t[5], X + R);
    cmp(t[7] - t_cd >= L, 1);
    cmp(pixel_array_supply_en, analog_supply_en);
    cmp(fault, 1'b0);
    cmp(wr_addr, SENSOR_CTRL_ADDR);
    cmp(wr_data[STREAM_BIT], 1'b1);
    cmp({stream_on, streaming, busy, wr_req}, 4'hC);
  endtask

  // abort while the analog rail has just come on
  task automatic abort_mid();
    start = 1'b1;
    for (int i = 0; i < 100 && analog_supply_en !== 1'b1; i++)
      @(negedge clock);
    cmp({io_supply_en, busy}, 2'h1);
    drop();
  endtask

  initial begin
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    check_off();
    run_seq(4'h0);
    drop();
    abort_mid();
    run_seq(4'h6);
    results();
  end

  // watchdog against a hung sequence
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
